// ---- hw/wdt_pkg.sv ----
// Package: constants and state record of the windowed watchdog timer
package wdt_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] WDT_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] WDT_SERVICE_OFFSET = 8'h04;
  localparam logic [7:0] WDT_STATUS_OFFSET = 8'h08;

  // ****************************************************************
  // Control register fields and reset values
  // ****************************************************************
  localparam int WDT_CTRL_WIN_BIT = 0;
  localparam int WDT_CTRL_CLKSEL_BIT = 1;
  localparam int WDT_CTRL_TSEL_LSB = 2;
  localparam logic [1:0] WDT_TSEL_OFF = 2'h0;
  localparam logic [1:0] WDT_TSEL_SHORT = 2'h1;
  localparam logic [1:0] WDT_TSEL_MID = 2'h2;
  localparam logic [1:0] WDT_TSEL_LONG = 2'h3;
  localparam logic [1:0] WDT_TSEL_RESET = WDT_TSEL_LONG;
  localparam logic WDT_CLKSEL_LP = 1'b0;
  localparam logic WDT_CLKSEL_BUS = 1'b1;
  localparam logic WDT_CLKSEL_RESET = WDT_CLKSEL_LP;
  localparam logic WDT_WIN_RESET = 1'b0;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int WDT_STAT_COUNT_LSB = 0;
  localparam int WDT_STAT_ARMED_BIT = 20;
  localparam int WDT_STAT_LOCKED_BIT = 21;
  localparam int WDT_STAT_RUN_BIT = 22;
  localparam int WDT_STAT_VLLS_BIT = 23;

  // ****************************************************************
  // Service keys
  // ****************************************************************
  localparam logic [7:0] WDT_KEY_FIRST = 8'h55;
  localparam logic [7:0] WDT_KEY_SECOND = 8'haa;

  // ****************************************************************
  // Timeout counts in cycles of the selected source
  // ****************************************************************
  localparam int WDT_CNT_W = 18;
  localparam logic [17:0] WDT_OVF_LP_SHORT = 18'h00020;
  localparam logic [17:0] WDT_OVF_LP_MID = 18'h00100;
  localparam logic [17:0] WDT_OVF_LP_LONG = 18'h00400;
  localparam logic [17:0] WDT_OVF_BUS_SHORT = 18'h02000;
  localparam logic [17:0] WDT_OVF_BUS_MID = 18'h10000;
  localparam logic [17:0] WDT_OVF_BUS_LONG = 18'h3ffff;
  localparam logic [17:0] WDT_WIN_BUS_SHORT = 18'h01800;
  localparam logic [17:0] WDT_WIN_BUS_MID = 18'h0c000;
  localparam logic [17:0] WDT_WIN_BUS_LONG = 18'h30000;

  // ****************************************************************
  // Module state
  // ****************************************************************
  typedef struct packed {
    logic locked;
    logic clk_sel;
    logic [1:0] tsel;
    logic win_en;
    logic armed;
    logic vlls_off;
    logic [17:0] count;
    logic rst_req;
    logic [1:0] rst_cause;
    logic [31:0] rdata;
    logic dp_sel;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [2:0] lp_sync;
    logic lp_level;
  } wdt_state_t;

  localparam logic [1:0] WDT_CAUSE_NONE = 2'h0;
  localparam logic [1:0] WDT_CAUSE_TIMEOUT = 2'h1;
  localparam logic [1:0] WDT_CAUSE_BADKEY = 2'h2;
  localparam logic [1:0] WDT_CAUSE_EARLY = 2'h3;

endpackage

// ---- hw/wdt_watchdog.sv ----
// Module: windowed watchdog timer with an AHB-Lite register slave
//
// Summary of operation
// - Counts 1 kHz clock or bus clock.
// - Enabled and counting after every reset.
// - Timeout select 00 disables, no reset.
// - Keys 0x55 then 0xAA restart count.
// - Service writes store no data.
// - Overflow before service requests system reset.
// - Any other service value resets immediately.
// - Clock select 0 is 1 kHz, 1 bus.
// - 1 kHz overflow at 2^5, 2^8, 2^10.
// - Bus overflow at 2^13, 2^16, 2^18.
// - Reset default 1 kHz, longest timeout.
// - Windowed bus mode: service in last quarter.
// - Early windowed service resets immediately.
// - Window enable ignored with 1 kHz clock.
// - Control register is write-once per reset.
// - Bus source holds count in debug/stop.
// - 1 kHz source clears count in debug/stop.
// - Very-low-leakage stop disables until reset.
//
// Register map: control at 0x00 (window, clock select, timeout), service
// keys at 0x04, read-only status at 0x08. Zero wait states, always OKAY.
// The control register locks on its first write; only hresetn unlocks it,
// so a lost program cannot switch the timer off afterwards.
// Limitation: the 1 kHz input is sampled by hclk, so it must be far slower
// than the bus clock; each of its rising edges counts exactly once.
// Trade-off: the bus-clock long constant holds 2^18 - 1, not 2^18,
// because the last count, not the overflow count, is what the 18-bit
// counter can hold; the timeout itself is still a full 2^18 counts.
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps

module wdt_watchdog #(
  parameter logic [17:0] OVF_BUS_SHORT = wdt_pkg::WDT_OVF_BUS_SHORT,
  parameter logic [17:0] OVF_BUS_MID = wdt_pkg::WDT_OVF_BUS_MID,
  parameter logic [17:0] OVF_BUS_LONG = wdt_pkg::WDT_OVF_BUS_LONG,
  parameter logic [17:0] WIN_BUS_SHORT = wdt_pkg::WDT_WIN_BUS_SHORT,
  parameter logic [17:0] WIN_BUS_MID = wdt_pkg::WDT_WIN_BUS_MID,
  parameter logic [17:0] WIN_BUS_LONG = wdt_pkg::WDT_WIN_BUS_LONG
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic lp_clk_1khz,
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic very_low_leakage_stop,
  output logic wdt_reset_req,
  output logic [1:0] wdt_reset_cause
);

  // ****************************************************************
  // State
  // ****************************************************************
  wdt_pkg::wdt_state_t s;
  wdt_pkg::wdt_state_t next_s;

  logic enabled;
  logic halted;
  logic lp_rise;
  logic tick;
  logic windowed;
  logic early;
  logic [17:0] ovf_last;
  logic [17:0] win_open;
  logic [7:0] key;
  logic addr_ok;
  logic addr_phase;
  logic ctrl_wr;
  logic svc_wr;
  logic key_first;
  logic key_second;
  logic key_bad;
  logic svc_arm;
  logic svc_done;
  logic ovf_hit;
  logic [17:0] count_step;
  logic [17:0] lp_last;
  logic [17:0] bus_last;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [31:0] read_word;

  // ****************************************************************
  // Last count before overflow on the slow source
  // ****************************************************************
  always_comb begin
    unique case (s.tsel)
      wdt_pkg::WDT_TSEL_OFF: begin
        // Timer off: value unused, the counter stays at zero
        lp_last = 18'h00000;
      end
      wdt_pkg::WDT_TSEL_SHORT: begin
        lp_last = wdt_pkg::WDT_OVF_LP_SHORT - 18'h00001;
      end
      wdt_pkg::WDT_TSEL_MID: begin
        lp_last = wdt_pkg::WDT_OVF_LP_MID - 18'h00001;
      end
      wdt_pkg::WDT_TSEL_LONG: begin
        lp_last = wdt_pkg::WDT_OVF_LP_LONG - 18'h00001;
      end
    endcase
  end

  // ****************************************************************
  // Last count before overflow on the bus clock
  // ****************************************************************
  always_comb begin
    unique case (s.tsel)
      wdt_pkg::WDT_TSEL_OFF: begin
        // Timer off: value unused, the counter stays at zero
        bus_last = 18'h00000;
      end
      wdt_pkg::WDT_TSEL_SHORT: begin
        bus_last = OVF_BUS_SHORT - 18'h00001;
      end
      wdt_pkg::WDT_TSEL_MID: begin
        bus_last = OVF_BUS_MID - 18'h00001;
      end
      wdt_pkg::WDT_TSEL_LONG: begin
        // Full scale 2^18 does not fit 18 bits; this is the last count
        bus_last = OVF_BUS_LONG;
      end
    endcase
  end

  // ****************************************************************
  // Window opening count
  // ****************************************************************
  always_comb begin
    unique case (s.tsel)
      wdt_pkg::WDT_TSEL_OFF: begin
        // No window while the timer is off
        win_open = 18'h00000;
      end
      wdt_pkg::WDT_TSEL_SHORT: begin
        win_open = WIN_BUS_SHORT;
      end
      wdt_pkg::WDT_TSEL_MID: begin
        win_open = WIN_BUS_MID;
      end
      wdt_pkg::WDT_TSEL_LONG: begin
        win_open = WIN_BUS_LONG;
      end
    endcase
  end

  // ****************************************************************
  // Selected overflow count
  // ****************************************************************
  assign ovf_last = s.clk_sel ? bus_last : lp_last;

  // ****************************************************************
  // Derived conditions
  // ****************************************************************
  assign enabled = (s.tsel != wdt_pkg::WDT_TSEL_OFF) && !s.vlls_off;
  assign halted = debug_mode || stop_mode;
  // Edge of the 1 kHz clock once stages two and three agree
  assign lp_rise = (s.lp_sync[1] == s.lp_sync[2]) && s.lp_sync[2]
                   && !s.lp_level;
  assign tick = (s.clk_sel == wdt_pkg::WDT_CLKSEL_BUS) ? 1'b1 : lp_rise;
  // Window has no meaning on the slow source
  assign windowed = s.win_en && (s.clk_sel == wdt_pkg::WDT_CLKSEL_BUS);
  assign early = windowed && (s.count < win_open);
  assign key = hwdata[7:0];
  assign addr_ok = (haddr[7:0] == wdt_pkg::WDT_CTRL_OFFSET)
                   || (haddr[7:0] == wdt_pkg::WDT_STATUS_OFFSET);

  // ****************************************************************
  // Counter step, before any bus write
  // ****************************************************************
  always_comb begin
    count_step = s.count;
    if (!enabled) begin
      count_step = 18'h00000;
    end else if (halted) begin
      // Slow source restarts from zero; bus source holds its value
      if (s.clk_sel == wdt_pkg::WDT_CLKSEL_LP) begin
        count_step = 18'h00000;
      end
    end else if (ovf_hit) begin
      count_step = 18'h00000;
    end else if (tick) begin
      count_step = s.count + 18'h00001;
    end
  end

  // ****************************************************************
  // Bus decode and service keys
  // ****************************************************************
  assign addr_phase = hsel && htrans[1] && hready;
  assign ctrl_wr = s.dp_sel && s.dp_wr
                   && (s.dp_addr == wdt_pkg::WDT_CTRL_OFFSET);
  assign svc_wr = s.dp_sel && s.dp_wr
                  && (s.dp_addr == wdt_pkg::WDT_SERVICE_OFFSET);
  // Only the low byte is a key; the upper bits are ignored
  assign key_first = (key == wdt_pkg::WDT_KEY_FIRST);
  assign key_second = (key == wdt_pkg::WDT_KEY_SECOND);
  assign key_bad = !key_first && !key_second;
  // Service is judged only while the timer runs
  assign svc_arm = svc_wr && enabled && key_first && !early;
  assign svc_done = svc_wr && enabled && key_second && !early && s.armed;
  // Timeout and a finished service in one cycle: the clear wins on the
  // count, the pulse is still sent
  assign ovf_hit = enabled && !halted && tick && (s.count == ovf_last);

  // ****************************************************************
  // Read words
  // ****************************************************************
  always_comb begin
    ctrl_word = 32'h00000000;
    ctrl_word[wdt_pkg::WDT_CTRL_WIN_BIT] = s.win_en;
    ctrl_word[wdt_pkg::WDT_CTRL_CLKSEL_BIT] = s.clk_sel;
    ctrl_word[wdt_pkg::WDT_CTRL_TSEL_LSB +: 2] = s.tsel;
  end

  always_comb begin
    stat_word = 32'h00000000;
    stat_word[wdt_pkg::WDT_STAT_COUNT_LSB +: 18] = s.count;
    stat_word[wdt_pkg::WDT_STAT_ARMED_BIT] = s.armed;
    stat_word[wdt_pkg::WDT_STAT_LOCKED_BIT] = s.locked;
    stat_word[wdt_pkg::WDT_STAT_RUN_BIT] = enabled;
    stat_word[wdt_pkg::WDT_STAT_VLLS_BIT] = s.vlls_off;
  end

  // Service and unmapped offsets read as zero
  always_comb begin
    read_word = 32'h00000000;
    if (!hwrite && addr_ok) begin
      if (haddr[7:0] == wdt_pkg::WDT_CTRL_OFFSET) begin
        read_word = ctrl_word;
      end else begin
        read_word = stat_word;
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.rst_req = 1'b0;

    // Synchroniser for the slow clock; stage 0 feeds only stage 1
    next_s.lp_sync = {s.lp_sync[1:0], lp_clk_1khz};
    if (s.lp_sync[1] == s.lp_sync[2]) begin
      next_s.lp_level = s.lp_sync[2];
    end

    // Sticky until the wake-up reset re-initialises everything
    if (very_low_leakage_stop) begin
      next_s.vlls_off = 1'b1;
    end

    // Counter
    next_s.count = count_step;
    if (!enabled) begin
      next_s.armed = 1'b0;
    end
    if (ovf_hit) begin
      next_s.rst_req = 1'b1;
      next_s.rst_cause = wdt_pkg::WDT_CAUSE_TIMEOUT;
    end

    // Data phase of a write
    if (s.dp_sel && s.dp_wr) begin
      if (ctrl_wr) begin
        if (!s.locked) begin
          next_s.locked = 1'b1;
          next_s.win_en = hwdata[wdt_pkg::WDT_CTRL_WIN_BIT];
          next_s.clk_sel = hwdata[wdt_pkg::WDT_CTRL_CLKSEL_BIT];
          next_s.tsel = hwdata[wdt_pkg::WDT_CTRL_TSEL_LSB +: 2];
          next_s.count = 18'h00000;
          next_s.armed = 1'b0;
        end
      end else if (svc_wr && enabled) begin
        // Nothing is stored; the write only drives the key sequence
        if (key_bad) begin
          next_s.rst_req = 1'b1;
          next_s.rst_cause = wdt_pkg::WDT_CAUSE_BADKEY;
          next_s.armed = 1'b0;
        end else if (early) begin
          next_s.rst_req = 1'b1;
          next_s.rst_cause = wdt_pkg::WDT_CAUSE_EARLY;
          next_s.armed = 1'b0;
        end else if (svc_arm) begin
          next_s.armed = 1'b1;
        end else if (svc_done) begin
          next_s.armed = 1'b0;
          next_s.count = 18'h00000;
        end
      end
    end

    // Address phase
    if (addr_phase) begin
      next_s.dp_sel = 1'b1;
      next_s.dp_wr = hwrite;
      next_s.dp_addr = haddr[7:0];
      next_s.rdata = read_word;
    end else if (hready) begin
      next_s.dp_sel = 1'b0;
      next_s.dp_wr = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.clk_sel <= wdt_pkg::WDT_CLKSEL_RESET;
      s.tsel <= wdt_pkg::WDT_TSEL_RESET;
      s.win_en <= wdt_pkg::WDT_WIN_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hrdata = s.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wdt_reset_req = s.rst_req;
  assign wdt_reset_cause = s.rst_cause;

endmodule

// ---- testbench/wdt_watchdog_properties.sv ----
// Checker: port-level properties of the watchdog timer
`timescale 1ns/10ps
module wdt_watchdog_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic very_low_leakage_stop,
  input wire logic wdt_reset_req,
  input wire logic [1:0] wdt_reset_cause
);
  // ****
  // Shadow of data phases and the locked timeout
  // ****
  logic dp_w, dp_r, lk, off;
  logic [7:0] dp_a;
  logic [1:0] ts;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_w <= 1'b0;
      dp_r <= 1'b0;
      dp_a <= 8'h00;
      lk <= 1'b0;
      ts <= 2'h3;
      off <= 1'b0;
    end else begin
      dp_w <= hsel && htrans[1] && hready && hwrite;
      dp_r <= hsel && htrans[1] && hready && !hwrite;
      dp_a <= haddr[7:0];
      if (dp_w && dp_a == 8'h00 && !lk) begin
        lk <= 1'b1;
        ts <= hwdata[3:2];
      end
      if (very_low_leakage_stop) begin
        off <= 1'b1;
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence svc_wr;
    dp_w && dp_a == 8'h04;
  endsequence
  sequence bad_key;
    hwdata[7:0] != 8'h55 && hwdata[7:0] != 8'haa && ts != 2'h0 && !off;
  endsequence
  a_pulse_single: assert property (
    wdt_reset_req |=> !wdt_reset_req) else $error("long reset request");
  a_badkey_reset: assert property (
    svc_wr ##0 bad_key |=> wdt_reset_req && wdt_reset_cause == 2'h2)
    else $error("bad key gave no reset");
  a_disabled_quiet: assert property (
    ts == 2'h0 && $past(ts) == 2'h0 |-> !wdt_reset_req)
    else $error("reset while disabled");
  a_vlls_quiet: assert property (
    off && $past(off) |-> !wdt_reset_req) else $error("reset after vlls");
  a_cause_pulse: assert property (
    $changed(wdt_reset_cause) |-> wdt_reset_req)
    else $error("cause changed without request");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_svc_read: assert property (
    dp_r && dp_a == 8'h04 |-> hrdata == 32'h0)
    else $error("service register held data");
  a_ctrl_read: assert property (
    dp_r && dp_a == 8'h00 && !$past(dp_w) |-> hrdata[3:2] == ts)
    else $error("timeout field not as first write");
endmodule
bind wdt_watchdog wdt_watchdog_properties chk_u (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .very_low_leakage_stop, .wdt_reset_req, .wdt_reset_cause);

// ---- testbench/windowed_watchdog_timer_test.sv ----
// Testbench: directed scenarios for the watchdog timer
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("MISMATCH %s exp %h got %h", n, e, g); num_errors++; end end
module windowed_watchdog_timer_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic lp_clk_1khz = 1'b0;
  logic debug_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic very_low_leakage_stop = 1'b0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, wdt_reset_req;
  logic [1:0] wdt_reset_cause;
  int num_errors = 0;
  int compares = 0;
  int pulses = 0;
  int n;
  always #5 hclk = ~hclk;
  // Low-power clock sped up to 20 bus cycles so runs stay short
  always #100 lp_clk_1khz = ~lp_clk_1khz;
  always @(posedge hclk) if (wdt_reset_req === 1'b1) pulses++;
  wdt_watchdog #(.OVF_BUS_SHORT(18'h40), .OVF_BUS_MID(18'h80),
    .OVF_BUS_LONG(18'hff), .WIN_BUS_SHORT(18'h30), .WIN_BUS_MID(18'h60))
    dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .lp_clk_1khz, .debug_mode, .stop_mode, .very_low_leakage_stop,
    .wdt_reset_req, .wdt_reset_cause);
  // ****
  // Bus and sequencing helpers
  // ****
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // All ones means keep the reset configuration unlocked
  task automatic rst_cfg(input logic [31:0] c);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    if (c !== 32'hffffffff) ahb(1'b1, 8'h00, c);
  endtask
  task automatic wait_pulse(input int lim);
    n = 0;
    while (wdt_reset_req !== 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic svc(input logic [31:0] k);
    ahb(1'b1, 8'h04, 32'h55);
    ahb(1'b1, 8'h04, k);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_defaults;
    rst_cfg(32'hffffffff);
    ahb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl_reset", 32'h0000000c, rd)
    ahb(1'b0, 8'h08, 32'h0);
    `CHK("running", 1'b1, rd[22])
    ahb(1'b1, 8'h04, 32'h55);
    ahb(1'b0, 8'h04, 32'h0);
    `CHK("svc_read", 32'h0, rd)
    ahb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    ahb(1'b1, 8'h00, 32'h6);
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl_lock", 32'h6, rd)
    $display("test defaults done");
  endtask
  task automatic t_ovf;
    for (int t = 1; t < 4; t++) begin
      rst_cfg({28'h0, t[1:0], 2'h2});
      wait_pulse(300);
      `CHK("bus_ovf", 1'b1, n >= (32 << t) - 2 && n <= (32 << t) + 2)
      `CHK("ovf_cause", 2'h1, wdt_reset_cause)
    end
    rst_cfg(32'h4);
    wait_pulse(700);
    `CHK("lp_ovf", 1'b1, n >= 615 && n <= 650)
    $display("test overflow done");
  endtask
  task automatic t_service;
    int p;
    rst_cfg(32'h6);
    p = pulses;
    repeat (5) begin
      repeat (40) @(posedge hclk);
      svc(32'hffffffaa);
    end
    `CHK("svc_pulses", p, pulses)
    ahb(1'b1, 8'h04, 32'h12);
    wait_pulse(4);
    `CHK("bad_lat", 1, n)
    `CHK("bad_cause", 2'h2, wdt_reset_cause)
    $display("test service done");
  endtask
  task automatic t_window;
    int p;
    rst_cfg(32'h7);
    repeat (50) @(posedge hclk);
    p = pulses;
    svc(32'haa);
    repeat (2) @(posedge hclk);
    `CHK("win_ok", p, pulses)
    ahb(1'b1, 8'h04, 32'h55);
    wait_pulse(4);
    `CHK("early_cause", 2'h3, wdt_reset_cause)
    rst_cfg(32'h5);
    p = pulses;
    svc(32'haa);
    repeat (4) @(posedge hclk);
    `CHK("lp_no_win", p, pulses)
    $display("test window done");
  endtask
  task automatic t_quiet;
    int p;
    rst_cfg(32'h0);
    p = pulses;
    repeat (300) @(posedge hclk);
    `CHK("off_quiet", p, pulses)
    rst_cfg(32'h6);
    debug_mode <= 1'b1;
    repeat (60) @(posedge hclk);
    debug_mode <= 1'b0;
    stop_mode <= 1'b1;
    repeat (60) @(posedge hclk);
    stop_mode <= 1'b0;
    wait_pulse(100);
    `CHK("hold_resume", 1'b1, n >= 58 && n <= 66)
    very_low_leakage_stop <= 1'b1;
    @(posedge hclk);
    very_low_leakage_stop <= 1'b0;
    p = pulses;
    repeat (300) @(posedge hclk);
    `CHK("vlls_quiet", p, pulses)
    rst_cfg(32'hffffffff);
    ahb(1'b0, 8'h08, 32'h0);
    `CHK("vlls_wake", 1'b1, rd[22])
    $display("test quiet done");
  endtask
  task automatic close_out;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    t_defaults();
    t_ovf();
    t_service();
    t_window();
    t_quiet();
    close_out();
  end
  initial begin
    #200000;
    num_errors++;
    $display("watchdog expired");
    close_out();
  end
endmodule
